// ===== verilog/sepp_ctrl.sv
`timescale 1ns/100ps
// Operation
// - protect bits choose none, C0h, 80h, all
// - status store changes only protect bits
// - status write cycle starts on select rise
// - power-up clears write permit latch
// - completed write clears write permit latch
// - exact clock count required, else dropped
// - array access ignored during write cycle
// - power-up standby; select must fall first
// - latch with guard high permits unprotected writes
// - guard low blocks array and status writes
// - guard low clears latch, cycle continues
// - select high gives standby after cycle
// - data-out released while deselected
// - data-in sampled on serial clock rise
// - data-out changes after serial clock fall
// - pause suspends sequence keeping its place
// - pause with clock high waits clock fall
// - serial clock and data-in ignored while paused
// - pause low releases data-out at once
// - protect bits are status bits 3, 2
// - busy flag reads one during cycle
// - bytes travel most significant bit first
module sepp_ctrl #(
   parameter int WC_CYCLES = sepp_pkg::WC_CYCLES
) (
   // clock and reset
   input logic ref_clk,
   input logic rst_b,
   input logic ce,
   // serial pins
   input logic sel_b,
   input logic sclk,
   input logic sdi,
   input logic pause_b,
   input logic wguard_b,
   output logic sdo,
   output logic sdo_oe,
   // status
   output sepp_pkg::sepp_status_t status,
   output logic standby
);

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   localparam int CW = sepp_pkg::WC_W;
   localparam logic [CW-1:0] WC_LOAD = CW'(WC_CYCLES);
   localparam logic [CW-1:0] WC_LAST = CW'(WC_CYCLES - 1);

   sepp_pkg::sepp_core_t s_r;
   sepp_pkg::sepp_core_t s_nxt;
   logic [sepp_pkg::NPIN-1:0] pin_in;
   logic [sepp_pkg::NPIN-1:0] filt_n;
   logic sel_fall;
   logic sel_rise;
   logic sck_rise;
   logic sck_fall;
   logic live;
   logic wr_ok;
   logic pb_we;
   logic [7:0] bits_in;
   logic [7:0] sr_byte;
   logic [7:0] pb_rdata;
   logic [7:0] arr_rdata;

   function automatic logic prot_hit(input logic [1:0] bp,
                                     input logic [7:0] a);
      unique case (bp)
         2'h0: prot_hit = 1'b0;
         2'h1: prot_hit = (a >= sepp_pkg::PROT_QTR);
         2'h2: prot_hit = (a >= sepp_pkg::PROT_HALF);
         2'h3: prot_hit = 1'b1;
      endcase
   endfunction

   assign pin_in = {wguard_b, pause_b, sdi, sclk, sel_b};

   // ------------------------------------------------------------
   // pin filter: a level counts once stages two and three agree
   // ------------------------------------------------------------
   for (genvar i = 0; i < sepp_pkg::NPIN; i++) begin : g_pin
      assign filt_n[i] = (s_r.p2[i] == s_r.p3[i]) ? s_r.p2[i] :
                         s_r.filt[i];
   end

   // ------------------------------------------------------------
   // page buffer and array
   // ------------------------------------------------------------
   sepp_mem #(
      .W(sepp_pkg::DATA_W),
      .D(sepp_pkg::PAGE_DEPTH),
      .AW(sepp_pkg::PAGE_W)
   ) u_page (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .ce(ce),
      .we(pb_we),
      .waddr(s_r.wptr),
      .wdata(bits_in),
      .raddr(s_r.cidx),
      .rdata(pb_rdata)
   );

   // programming walks the page one byte a cycle
   sepp_mem #(
      .W(sepp_pkg::DATA_W),
      .D(sepp_pkg::ARR_DEPTH),
      .AW(sepp_pkg::ADDR_W)
   ) u_array (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .ce(ce),
      .we(s_r.cv),
      .waddr({s_r.pg, s_r.cidx_d}),
      .wdata(pb_rdata),
      .raddr(s_r.addr),
      .rdata(arr_rdata)
   );

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      s_nxt = s_r;
      pb_we = 1'b0;
      s_nxt.p1 = pin_in;
      s_nxt.p2 = s_r.p1;
      s_nxt.p3 = s_r.p2;
      s_nxt.filt = filt_n;
      sel_fall = s_r.filt[sepp_pkg::PIN_SEL] &
                 ~filt_n[sepp_pkg::PIN_SEL];
      sel_rise = ~s_r.filt[sepp_pkg::PIN_SEL] &
                 filt_n[sepp_pkg::PIN_SEL];
      sck_rise = ~s_r.filt[sepp_pkg::PIN_SCLK] &
                 filt_n[sepp_pkg::PIN_SCLK];
      sck_fall = s_r.filt[sepp_pkg::PIN_SCLK] &
                 ~filt_n[sepp_pkg::PIN_SCLK];
      // clock edges seen while paused or pausing are dropped
      live = s_r.sel_act & ~s_r.paused &
             s_r.filt[sepp_pkg::PIN_PAUSE];
      bits_in = {s_r.sh[6:0], filt_n[sepp_pkg::PIN_SDI]};
      sr_byte = {4'h0, s_r.bp, s_r.latch, s_r.busy};
      wr_ok = (s_r.bcnt == 3'h0) & s_r.latch &
              s_r.filt[sepp_pkg::PIN_WG] & ~s_r.busy;
      s_nxt.ld = {s_r.ld[0], 1'b0};

      // write cycle timer keeps running whatever select does
      if (s_r.wcnt != '0) begin
         s_nxt.wcnt = s_r.wcnt - 1'b1;
      end

      // page commit: buffer read, array write one cycle later
      s_nxt.cv = s_r.commit & s_r.mask[s_r.cidx];
      s_nxt.cidx_d = s_r.cidx;
      if (s_r.commit) begin
         s_nxt.cidx = s_r.cidx + 4'h1;
         if (s_r.cidx == 4'hf) begin
            s_nxt.commit = 1'b0;
         end
      end

      // pause enters only with the clock low; it leaves with the clock low or on deselect
      if (!s_r.sel_act) begin
         s_nxt.paused = 1'b0;
      end else if (!s_r.paused && !s_r.filt[sepp_pkg::PIN_PAUSE] &&
                   !s_r.filt[sepp_pkg::PIN_SCLK]) begin
         s_nxt.paused = 1'b1;
      end else if (s_r.paused && s_r.filt[sepp_pkg::PIN_PAUSE] &&
                   !s_r.filt[sepp_pkg::PIN_SCLK]) begin
         s_nxt.paused = 1'b0;
      end

      if (s_r.ld[1]) begin
         s_nxt.obyte = arr_rdata;
      end

      if (sel_fall && !s_r.sel_act) begin
         s_nxt.sel_act = 1'b1;
         s_nxt.st = sepp_pkg::ST_CMD;
         s_nxt.bcnt = 3'h0;
         s_nxt.ocnt = 3'h0;
      end else if (sel_rise && s_r.sel_act) begin
         s_nxt.sel_act = 1'b0;
         s_nxt.paused = 1'b0;
         s_nxt.st = sepp_pkg::ST_IDLE;
         if (s_r.st == sepp_pkg::ST_LATCH && s_r.bcnt == 3'h0) begin
            s_nxt.latch = s_r.set_op;
         end
         if (s_r.st == sepp_pkg::ST_SDONE && wr_ok) begin
            // only the protect bits take the written byte
            s_nxt.bp = s_r.sbyte[sepp_pkg::SR_BP_HI:
                                 sepp_pkg::SR_BP_LO];
            s_nxt.wcnt = WC_LOAD;
            s_nxt.latch = 1'b0;
         end
         if (s_r.st == sepp_pkg::ST_WDATA && wr_ok && |s_r.mask &&
             !prot_hit(s_r.bp, {s_r.pg, 4'h0})) begin
            s_nxt.wcnt = WC_LOAD;
            s_nxt.latch = 1'b0;
            s_nxt.commit = 1'b1;
            s_nxt.cidx = 4'h0;
         end
      end else if (live && sck_rise) begin
         s_nxt.sh = bits_in;
         s_nxt.bcnt = s_r.bcnt + 3'h1;
         if (s_r.bcnt == 3'h7) begin
            unique case (s_r.st)
               sepp_pkg::ST_CMD: begin
                  s_nxt.st = sepp_pkg::ST_IGNORE;
                  if (bits_in[7:4] == sepp_pkg::OP_HI) begin
                     unique case (bits_in[2:0])
                        sepp_pkg::READ_CMD: begin
                           s_nxt.rd = 1'b1;
                           if (!s_r.busy) begin
                              s_nxt.st = sepp_pkg::ST_ADDR;
                           end
                        end
                        sepp_pkg::WRITE_CMD: begin
                           s_nxt.rd = 1'b0;
                           if (!s_r.busy) begin
                              s_nxt.st = sepp_pkg::ST_ADDR;
                           end
                        end
                        sepp_pkg::STATUS_STORE_CMD: begin
                           if (!s_r.busy) begin
                              s_nxt.st = sepp_pkg::ST_SDATA;
                           end
                        end
                        sepp_pkg::STATUS_READ_CMD: begin
                           s_nxt.st = sepp_pkg::ST_RSTAT;
                           s_nxt.obyte = sr_byte;
                           s_nxt.ocnt = 3'h0;
                        end
                        sepp_pkg::PERMIT_SET_CMD: begin
                           s_nxt.st = sepp_pkg::ST_LATCH;
                           s_nxt.set_op = 1'b1;
                        end
                        sepp_pkg::PERMIT_CLEAR_CMD: begin
                           s_nxt.st = sepp_pkg::ST_LATCH;
                           s_nxt.set_op = 1'b0;
                        end
                        default: begin
                           s_nxt.st = sepp_pkg::ST_IGNORE;
                        end
                     endcase
                  end
               end
               sepp_pkg::ST_ADDR: begin
                  s_nxt.addr = bits_in;
                  s_nxt.pg = bits_in[7:4];
                  s_nxt.wptr = bits_in[3:0];
                  s_nxt.mask = '0;
                  s_nxt.ocnt = 3'h0;
                  if (s_r.rd) begin
                     s_nxt.st = sepp_pkg::ST_RDATA;
                     s_nxt.ld = 2'h1;
                  end else begin
                     s_nxt.st = sepp_pkg::ST_WDATA;
                  end
               end
               sepp_pkg::ST_WDATA: begin
                  // the pointer wraps inside the page
                  pb_we = 1'b1;
                  s_nxt.mask[s_r.wptr] = 1'b1;
                  s_nxt.wptr = s_r.wptr + 4'h1;
               end
               sepp_pkg::ST_SDATA: begin
                  s_nxt.sbyte = bits_in;
                  s_nxt.st = sepp_pkg::ST_SDONE;
               end
               sepp_pkg::ST_SDONE, sepp_pkg::ST_LATCH: begin
                  // extra bytes spoil the sequence
                  s_nxt.st = sepp_pkg::ST_IGNORE;
               end
               default: begin
               end
            endcase
         end
      end else if (live && sck_fall &&
                   (s_r.st == sepp_pkg::ST_RDATA ||
                    s_r.st == sepp_pkg::ST_RSTAT)) begin
         s_nxt.sdo = s_r.obyte[~s_r.ocnt];
         s_nxt.ocnt = s_r.ocnt + 3'h1;
         if (s_r.ocnt == 3'h7) begin
            if (s_r.st == sepp_pkg::ST_RSTAT) begin
               s_nxt.obyte = sr_byte;
            end else begin
               // address rolls over from the top to zero
               s_nxt.addr = s_r.addr + 8'h01;
               s_nxt.ld = 2'h1;
            end
         end
      end

      if (!s_r.filt[sepp_pkg::PIN_WG]) begin
         s_nxt.latch = 1'b0;
      end
      s_nxt.busy = (s_nxt.wcnt != '0);
      s_nxt.standby = ~s_nxt.sel_act & ~s_nxt.busy;
      s_nxt.sdo_oe = s_nxt.sel_act & ~s_nxt.paused &
                     s_r.filt[sepp_pkg::PIN_PAUSE] &
                     filt_n[sepp_pkg::PIN_PAUSE] &
                     (s_nxt.st == sepp_pkg::ST_RDATA ||
                      s_nxt.st == sepp_pkg::ST_RSTAT);
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         s_r <= '0;
         s_r.p1 <= sepp_pkg::PIN_RST;
         s_r.p2 <= sepp_pkg::PIN_RST;
         s_r.p3 <= sepp_pkg::PIN_RST;
         s_r.filt <= sepp_pkg::PIN_RST;
         s_r.st <= sepp_pkg::ST_IDLE;
         s_r.bp <= sepp_pkg::BP_RST;
         s_r.latch <= 1'b0;
         s_r.standby <= 1'b1;
      end else if (ce) begin
         s_r <= s_nxt;
      end
   end

   assign sdo = s_r.sdo;
   assign sdo_oe = s_r.sdo_oe;
   assign standby = s_r.standby;
   assign status.protect_sel_hi = s_r.bp[1];
   assign status.protect_sel_lo = s_r.bp[0];
   assign status.write_permit_latch = s_r.latch;
   assign status.write_busy_flag = s_r.busy;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   logic [CW-1:0] busy_len;

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         busy_len <= '0;
      end else if (ce) begin
         busy_len <= s_r.busy ? busy_len + 1'b1 : '0;
      end
   end

   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   sequence wc_start_s;
      !s_r.busy ##1 s_r.busy;
   endsequence

   sequence pause_start_s;
      !s_r.paused ##1 s_r.paused;
   endsequence

   guard_clear_a: assert property (
      (ce && !s_r.filt[sepp_pkg::PIN_WG]) |=> !s_r.latch)
      else $error("latch set while guard low");

   busy_len_a: assert property (
      (ce && s_r.busy && !s_nxt.busy) |-> busy_len == WC_LAST)
      else $error("write cycle length wrong");

   start_sel_a: assert property (
      wc_start_s |-> s_r.filt[sepp_pkg::PIN_SEL] &&
                     !$past(s_r.filt[sepp_pkg::PIN_SEL]))
      else $error("write cycle began without select rise");

   start_latch_a: assert property (
      wc_start_s |-> !s_r.latch && $past(s_r.latch) &&
                     $past(s_r.filt[sepp_pkg::PIN_WG]))
      else $error("write cycle permit handling wrong");

   prot_page_a: assert property (
      $rose(s_r.commit) |-> !prot_hit(s_r.bp, {s_r.pg, 4'h0}))
      else $error("protected page programmed");

   busy_access_a: assert property (
      s_r.busy |-> !(s_r.st inside {sepp_pkg::ST_RDATA,
                                    sepp_pkg::ST_WDATA}))
      else $error("array access during write cycle");

   desel_tri_a: assert property (
      !s_r.sel_act |-> !s_r.sdo_oe)
      else $error("data-out driven while deselected");

   pause_tri_a: assert property (
      (ce && !s_r.filt[sepp_pkg::PIN_PAUSE]) |=> !s_r.sdo_oe)
      else $error("data-out driven while pause low");

   pause_entry_a: assert property (
      pause_start_s |-> $past(s_r.filt[sepp_pkg::PIN_SCLK]) == 1'b0)
      else $error("pause entered with clock high");

   standby_busy_a: assert property (
      s_r.busy |-> !s_r.standby)
      else $error("standby during write cycle");

endmodule

// ===== verilog/sepp_pkg.sv
package sepp_pkg;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 50;
   // programming time, a plain default
   localparam int T_WC_NS = 5000000;
   localparam int WC_CYCLES = T_WC_NS / CLK_PERIOD_NS;
   localparam int WC_W = 24;

   // ------------------------------------------------------------
   // pin bundle positions and reset levels
   // ------------------------------------------------------------
   localparam int NPIN = 5;
   localparam int PIN_SEL = 0;
   localparam int PIN_SCLK = 1;
   localparam int PIN_SDI = 2;
   localparam int PIN_PAUSE = 3;
   localparam int PIN_WG = 4;
   // select starts low so that a real high must be seen first
   localparam logic [NPIN-1:0] PIN_RST = 5'h08;

   // ------------------------------------------------------------
   // instructions: upper nibble zero, bit 3 ignored
   // ------------------------------------------------------------
   localparam logic [3:0] OP_HI = 4'h0;
   localparam logic [2:0] READ_CMD = 3'h3;
   localparam logic [2:0] WRITE_CMD = 3'h2;
   localparam logic [2:0] PERMIT_CLEAR_CMD = 3'h4;
   localparam logic [2:0] PERMIT_SET_CMD = 3'h6;
   localparam logic [2:0] STATUS_READ_CMD = 3'h5;
   localparam logic [2:0] STATUS_STORE_CMD = 3'h1;

   // ------------------------------------------------------------
   // status byte and protection
   // ------------------------------------------------------------
   localparam int SR_BP_LO = 2;
   localparam int SR_BP_HI = 3;
   localparam logic [1:0] BP_RST = 2'h0;
   localparam logic [7:0] PROT_QTR = 8'hc0;
   localparam logic [7:0] PROT_HALF = 8'h80;

   // ------------------------------------------------------------
   // array geometry
   // ------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int PAGE_W = 4;
   localparam int ARR_DEPTH = 256;
   localparam int PAGE_DEPTH = 16;

   typedef enum logic [3:0] {
      ST_IDLE, ST_CMD, ST_ADDR, ST_WDATA, ST_RDATA,
      ST_RSTAT, ST_SDATA, ST_SDONE, ST_LATCH, ST_IGNORE
   } sepp_phase_t;

   typedef struct packed {
      logic protect_sel_hi;
      logic protect_sel_lo;
      logic write_permit_latch;
      logic write_busy_flag;
   } sepp_status_t;

   typedef struct packed {
      logic [NPIN-1:0] p1;
      logic [NPIN-1:0] p2;
      logic [NPIN-1:0] p3;
      logic [NPIN-1:0] filt;
      sepp_phase_t st;
      logic sel_act;
      logic paused;
      logic [DATA_W-1:0] sh;
      logic [2:0] bcnt;
      logic rd;
      logic set_op;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] obyte;
      logic [2:0] ocnt;
      logic [1:0] ld;
      logic [PAGE_W-1:0] pg;
      logic [PAGE_W-1:0] wptr;
      logic [PAGE_DEPTH-1:0] mask;
      logic [DATA_W-1:0] sbyte;
      logic commit;
      logic [PAGE_W-1:0] cidx;
      logic cv;
      logic [PAGE_W-1:0] cidx_d;
      logic [WC_W-1:0] wcnt;
      logic busy;
      logic latch;
      logic [1:0] bp;
      logic sdo;
      logic sdo_oe;
      logic standby;
   } sepp_core_t;

endpackage

// ===== verilog/sepp_mem.sv
`timescale 1ns/100ps
module sepp_mem #(
   parameter int W = 8,
   parameter int D = 256,
   parameter int AW = 8
) (
   // clock and reset
   input logic ref_clk,
   input logic rst_b,
   input logic ce,
   // write port
   input logic we,
   input logic [AW-1:0] waddr,
   input logic [W-1:0] wdata,
   // read port
   input logic [AW-1:0] raddr,
   output logic [W-1:0] rdata
);

   typedef struct packed {
      logic [D-1:0][W-1:0] cells;
      logic [W-1:0] rdata_r;
   } sepp_mem_t;

   sepp_mem_t m_r;
   sepp_mem_t m_nxt;

   always_comb begin
      m_nxt = m_r;
      if (we) begin
         m_nxt.cells[waddr] = wdata;
      end
      m_nxt.rdata_r = m_r.cells[raddr];
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         // erased cells read as all ones
         m_r <= '1;
      end else if (ce) begin
         m_r <= m_nxt;
      end
   end

   assign rdata = m_r.rdata_r;

endmodule

// ===== tb/sepp_master.sv
`timescale 1ns/100ps
module sepp_master (
   // clock
   input wire logic ref_clk,
   // serial pins
   input wire logic sdo,
   output logic sel_b,
   output logic sclk,
   output logic sdi
);
   initial begin
      sel_b = 1'b1;
      sclk = 1'b0;
      sdi = 1'b0;
   end

   // ----------------------------------------
   // timing helpers
   // ----------------------------------------
   task automatic wt(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   // read data is taken just before the fall, where it is surely settled
   task automatic xbit(input logic b, output logic r);
      sdi = b;
      wt(4);
      sclk = 1'b1;
      wt(4);
      r = sdo;
      sclk = 1'b0;
   endtask

   task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         xbit(tx[i], rx[i]);
      end
   endtask

   // ----------------------------------------
   // framing, clock held low at select edges
   // ----------------------------------------
   task automatic open_frame();
      sel_b = 1'b0;
      wt(8);
   endtask

   // released data line flips so that a held level is never mistaken
   task automatic close_frame();
      wt(4);
      sel_b = 1'b1;
      sdi = ~sdi;
      wt(8);
   endtask
endmodule

// ===== tb/tb_serial_eeprom_protect_pause.sv
`timescale 1ns/100ps
module tb_serial_eeprom_protect_pause;
   localparam int WC = 600;
   typedef struct packed {
      logic [1:0] bp;
      logic [7:0] a;
      logic go;
   } sepp_row_t;
   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   logic pause_b = 1'b1;
   logic wguard_b = 1'b1;
   logic ce = 1'b1;
   logic sel_b, sclk, sdi, sdo, sdo_oe, standby;
   sepp_pkg::sepp_status_t status;
   int num_errors = 0;
   int comparisons = 0;
   int run = 0;
   int blen = 0;
   logic [7:0] rx;
   logic bx;
   sepp_row_t rows [7] = '{'{2'h0, 8'hff, 1'b1}, '{2'h1, 8'hbf, 1'b1},
      '{2'h1, 8'hc0, 1'b0}, '{2'h2, 8'h7f, 1'b1}, '{2'h2, 8'h80, 1'b0},
      '{2'h3, 8'h00, 1'b0}, '{2'h0, 8'h00, 1'b1}};

   always #25 ref_clk = ~ref_clk;

   sepp_ctrl #(.WC_CYCLES(WC)) dut (.ref_clk(ref_clk), .rst_b(rst_b),
      .ce(ce), .sel_b(sel_b), .sclk(sclk), .sdi(sdi), .pause_b(pause_b),
      .wguard_b(wguard_b), .sdo(sdo), .sdo_oe(sdo_oe), .status(status),
      .standby(standby));
   sepp_master m (.ref_clk(ref_clk), .sdo(sdo), .sel_b(sel_b),
      .sclk(sclk), .sdi(sdi));

   // length of the last busy stretch, in clock cycles
   always @(posedge ref_clk) begin
      if (status.write_busy_flag === 1'b1) begin
         run <= run + 1;
      end else if (run != 0) begin
         blen <= run;
         run <= 0;
      end
   end

   // ----------------------------------------
   // checking and closing
   // ----------------------------------------
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wrap_up();
      if (num_errors == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic wait_idle();
      int n = 800;
      while (status.write_busy_flag !== 1'b0 && n > 0) begin
         m.wt(1);
         n--;
      end
      // let the busy length counter take the finished stretch
      m.wt(1);
      if (n == 0) begin
         num_errors++;
         wrap_up();
      end
   endtask

   // ----------------------------------------
   // frames
   // ----------------------------------------
   task automatic frame3(input logic [7:0] c, a, d, output logic [7:0] v);
      m.open_frame();
      m.xbyte(c, v);
      m.xbyte(a, v);
      m.xbyte(d, v);
      m.close_frame();
   endtask

   // opcode carries the don't-care bit set
   task automatic permit_set();
      m.open_frame();
      m.xbyte(8'h0e, rx);
      m.close_frame();
   endtask

   task automatic stat_read(output logic [7:0] v);
      m.open_frame();
      m.xbyte(8'h05, v);
      m.xbyte(8'h00, v);
      m.close_frame();
      chk("sdo_oe idle", sdo_oe, 0);
   endtask

   task automatic store(input logic [1:0] bp);
      permit_set();
      m.open_frame();
      m.xbyte(8'h01, rx);
      m.xbyte({4'ha, bp, 2'h2}, rx);
      m.close_frame();
   endtask

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (4) @(posedge ref_clk);
      #1;
      chk("standby rst", standby, 1);
      chk("status rst", status, 0);
      chk("sdo_oe rst", sdo_oe, 0);
      rst_b = 1'b1;
      m.wt(8);
      frame3(8'h02, 8'h10, 8'h33, rx);
      chk("busy no latch", status.write_busy_flag, 0);
      foreach (rows[i]) begin
         store(rows[i].bp);
         chk("busy store", status.write_busy_flag, 1);
         chk("latch store", status.write_permit_latch, 0);
         wait_idle();
         chk("busy len", blen, WC);
         chk("bp", {status.protect_sel_hi, status.protect_sel_lo},
            rows[i].bp);
         stat_read(rx);
         chk("stat byte", rx[3:0], {rows[i].bp, 2'h0});
         permit_set();
         frame3(8'h02, rows[i].a, rows[i].a ^ 8'h5a, rx);
         chk("busy wr", status.write_busy_flag, rows[i].go);
         chk("latch wr", status.write_permit_latch, !rows[i].go);
         wait_idle();
         frame3(8'h03, rows[i].a, 8'h00, rx);
         chk("data", rx, rows[i].go ? rows[i].a ^ 8'h5a : 8'hff);
      end
      // one bit too many abandons the store
      permit_set();
      m.open_frame();
      m.xbyte(8'h01, rx);
      m.xbyte(8'h0c, rx);
      m.xbit(1'b0, bx);
      m.close_frame();
      chk("busy extra", status.write_busy_flag, 0);
      chk("bp kept", status.protect_sel_hi, 0);
      // guard low clears the latch and wins over a set
      wguard_b = 1'b0;
      m.wt(8);
      chk("latch guard", status.write_permit_latch, 0);
      permit_set();
      frame3(8'h02, 8'h30, 8'h44, rx);
      chk("busy guard", status.write_busy_flag, 0);
      stat_read(rx);
      chk("stat guard", rx[3:0], 4'h0);
      wguard_b = 1'b1;
      // a running cycle survives guard low, deselect and a read attempt
      permit_set();
      frame3(8'h02, 8'h20, 8'h11, rx);
      wguard_b = 1'b0;
      chk("standby busy", standby, 0);
      stat_read(rx);
      chk("busy bit", rx[0], 1);
      m.open_frame();
      m.xbyte(8'h03, rx);
      m.xbyte(8'h20, rx);
      m.xbyte(8'h00, rx);
      chk("read in cycle", sdo_oe, 0);
      m.close_frame();
      wait_idle();
      chk("busy len guard", blen, WC);
      chk("standby after", standby, 1);
      wguard_b = 1'b1;
      frame3(8'h03, 8'h20, 8'h00, rx);
      chk("data guard", rx, 8'h11);
      // pause in mid-byte keeps the bit position
      permit_set();
      m.open_frame();
      m.xbyte(8'h05, rx);
      for (int i = 7; i > 3; i--) begin
         m.xbit(1'b0, rx[i]);
      end
      m.wt(8);
      pause_b = 1'b0;
      m.wt(5);
      chk("sdo_oe pause", sdo_oe, 0);
      m.xbit(1'b1, bx);
      m.wt(4);
      pause_b = 1'b1;
      m.wt(8);
      for (int i = 3; i >= 0; i--) begin
         m.xbit(1'b0, rx[i]);
      end
      m.close_frame();
      chk("paused byte", rx[3:0], 4'h2);
      // clock enable low freezes the write cycle timer
      permit_set();
      frame3(8'h02, 8'h30, 8'h55, rx);
      ce = 1'b0;
      m.wt(100);
      chk("busy frozen", status.write_busy_flag, 1);
      ce = 1'b1;
      wait_idle();
      chk("busy len frozen", blen, WC + 100);
      wrap_up();
   end
endmodule
